// ==== core/pio_pkg.sv ====
// shared constants and types for the 24-line parallel io block
package pio_pkg;

  // line and bus geometry
  localparam int LINE_COUNT = 24;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;

  // word indices of the io space (byte address is twice the index)
  localparam logic [5:0] IDX_OUT_LOW = 6'h00;
  localparam logic [5:0] IDX_OUT_HIGH = 6'h01;
  localparam logic [5:0] IDX_IN_LOW = 6'h02;
  localparam logic [5:0] IDX_IN_HIGH = 6'h03;
  localparam logic [5:0] IDX_CTRL = 6'h04;

  // control register layout
  localparam int CTRL_W = 4;
  localparam int CTRL_DB_EN = 0;
  localparam int CTRL_POL = 1;
  localparam int CTRL_MODE = 2;
  localparam int CTRL_MASTER = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // all lines released after reset
  localparam logic [23:0] LINE_RESET = 24'hFFFFFF;
  localparam int MASTER_OUT_LINE = 22;
  localparam int SLAVE_IN_LINE = 23;

  // identification memory layout, word index = (odd byte address - 1) / 2
  localparam int ID_DEPTH = 32;
  localparam logic [5:0] ID_IDX_I = 6'h00;
  localparam logic [5:0] ID_IDX_P = 6'h01;
  localparam logic [5:0] ID_IDX_A = 6'h02;
  localparam logic [5:0] ID_IDX_C = 6'h03;
  localparam logic [5:0] ID_IDX_MFR = 6'h04;
  localparam logic [5:0] ID_IDX_MODEL = 6'h05;
  localparam logic [5:0] ID_IDX_REV = 6'h06;
  localparam logic [5:0] ID_IDX_COUNT = 6'h0A;
  localparam logic [5:0] ID_IDX_CRC = 6'h0B;
  localparam logic [7:0] ID_ASCII_I = 8'h49;
  localparam logic [7:0] ID_ASCII_P = 8'h50;
  localparam logic [7:0] ID_ASCII_A = 8'h41;
  localparam logic [7:0] ID_ASCII_C = 8'h43;
  localparam logic [7:0] ID_USED_COUNT = 8'h0C;
  localparam logic [7:0] ID_ZERO = 8'h00;

  // which source answers the current read
  typedef enum logic [0:0] {ACC_IO, ACC_ID} pio_acc_e;

endpackage : pio_pkg

// ==== core/pio_ident_memory.sv ====
// read-only identification memory with registered read data
`timescale 1ns/1ps
module pio_ident_memory #(
  parameter logic [7:0] MFR_CODE = 8'h11,   // arbitrary value
  parameter logic [7:0] MODEL_CODE = 8'h22, // arbitrary value
  parameter logic [7:0] REV_CODE = 8'h01,   // arbitrary value
  parameter logic [7:0] CRC_CODE = 8'h5A    // arbitrary value
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic readEn,
  input wire logic [5:0] readIndex,
  output logic [7:0] readData
);

  typedef struct packed {
    logic [7:0] data; // last byte read
  } pio_rom_s;

  pio_rom_s rom_reg;
  pio_rom_s rom_next;

  // constant table; index 7 to 9 and the user area read zero
  function automatic logic [7:0] lookup(input logic [5:0] idx);
    logic [7:0] v;
    v = pio_pkg::ID_ZERO;
    if (idx == pio_pkg::ID_IDX_I) begin
      v = pio_pkg::ID_ASCII_I; // see [RQ2]
    end else if (idx == pio_pkg::ID_IDX_P) begin
      v = pio_pkg::ID_ASCII_P;
    end else if (idx == pio_pkg::ID_IDX_A) begin
      v = pio_pkg::ID_ASCII_A;
    end else if (idx == pio_pkg::ID_IDX_C) begin
      v = pio_pkg::ID_ASCII_C;
    end else if (idx == pio_pkg::ID_IDX_MFR) begin
      v = MFR_CODE;
    end else if (idx == pio_pkg::ID_IDX_MODEL) begin
      v = MODEL_CODE;
    end else if (idx == pio_pkg::ID_IDX_REV) begin
      v = REV_CODE; // see [RQ4]
    end else if (idx == pio_pkg::ID_IDX_COUNT) begin
      v = pio_pkg::ID_USED_COUNT; // see [RQ3]
    end else if (idx == pio_pkg::ID_IDX_CRC) begin
      v = CRC_CODE;
    end
    return v;
  endfunction : lookup

  // load a byte only when a new read is taken, so holds keep it stable
  always_comb begin
    rom_next = rom_reg;
    if (readEn) begin
      rom_next.data = lookup(readIndex); // see [RQ1]
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rom_reg <= '0;
    end else begin
      rom_reg <= rom_next;
    end
  end

  assign readData = rom_reg.data;

endmodule : pio_ident_memory

// ==== core/pio_parallel_io.sv ====
// 24-line open-collector parallel io with double-buffered lines
// How it works
// [RQ1] 32-byte read-only identification memory inside logic
// [RQ2] odd bytes: IPAC, maker, model, revision codes
// [RQ3] reserved, driver id zero; count, crc; user area
// [RQ4] identification memory carries a revision byte
// [RQ5] all control logic runs on bus clock
// [RQ6] answer io and id selects; ignore memory
// [RQ7] acknowledge the cycle after select, no waits
// [RQ8] acknowledge stays while select is held
// [RQ9] write captured on rising clock after select
// [RQ10] line latch loads on falling edge normally
// [RQ11] double buffering: line latch on link edge
// [RQ12] polarity bit picks rising or falling edge
// [RQ13] control bits are zero after reset
// [RQ14] offsets 0, 2 read back internal latch
// [RQ15] offsets 4, 6 read input register
// [RQ16] input register shares line latch clock edge
// [RQ17] software sets mode and master for master
// [RQ18] master redrives link clock on line 23
// [RQ19] mode bit takes link clock from line 24
// [RQ20] software preps lines 23, 24 before master
// [RQ21] one releases line, zero drives low
// [RQ22] lines 1-16 low word, 17-24 high byte
`timescale 1ns/1ps
module pio_parallel_io #(
  parameter logic [7:0] MFR_CODE = 8'h11,   // arbitrary value
  parameter logic [7:0] MODEL_CODE = 8'h22, // arbitrary value
  parameter logic [7:0] REV_CODE = 8'h01,   // arbitrary value
  parameter logic [7:0] CRC_CODE = 8'h5A    // arbitrary value
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic dbClk,
  input wire logic ioSelN,
  input wire logic idSelN,
  input wire logic memSelN,
  input wire logic rdWrN,
  input wire logic [5:0] addr,
  input wire logic [15:0] busDataIn,
  output logic [15:0] busDataOut,
  output logic busDataOe,
  input wire logic byteSel0N,
  input wire logic byteSel1N,
  output logic ackN,
  input wire logic [23:0] lineIn,
  output logic [23:0] lineOut,
  output logic [23:0] lineOe
);

  // bus-clock state, rising edge
  typedef struct packed {
    logic [23:0] intLatch;   // internal output latch
    logic [3:0] ctrl;        // control bits
    logic ack;               // acknowledge, a select seen last cycle
    logic readOut;           // current access is a read
    pio_pkg::pio_acc_e acc;  // source of read data
    logic [15:0] rdData;     // io read data
    logic [23:0] lineMeta;   // line synchroniser, first stage
    logic [23:0] lineSync;   // line synchroniser, second stage
    logic [23:0] shadow;     // latch word offered to the link side
    logic outReq;            // toggles when shadow is offered
    logic outAckMeta;
    logic outAckSync;
    logic inReqMeta;
    logic inReqSync;
    logic inAck;             // toggles when linkInput is taken
    logic [23:0] linkInput;  // input register word from the link side
  } pio_bus_s;

  // bus-clock state, falling edge
  typedef struct packed {
    logic [23:0] lineLatch;  // line latch without double buffering
    logic [23:0] inReg;      // input register without double buffering
  } pio_fall_s;

  // link-clock state
  typedef struct packed {
    logic reqMeta;
    logic reqSync;
    logic ackTog;            // returns outReq once shadow is copied
    logic [23:0] copy;       // link-side copy of the internal latch
    logic [23:0] lineLatch;  // double-buffered line latch
    logic [23:0] inCapture;  // double-buffered input register
    logic [23:0] hold;       // stable word offered to the bus side
    logic inReq;
    logic inAckMeta;
    logic inAckSync;
  } pio_link_s;

  pio_bus_s bus_reg;
  pio_bus_s bus_next;
  pio_fall_s fall_reg;
  pio_fall_s fall_next;
  pio_link_s link_reg;
  pio_link_s link_next;

  logic sel;            // any select this block answers
  logic first;          // first cycle of a select
  logic ioFirst;        // first cycle of an io select
  logic idFirst;        // first cycle of an id select
  logic [23:0] inValue; // input register as seen by reads
  logic [23:0] lineLatch;
  logic [7:0] idData;
  logic linkSrc;        // chosen double-buffer clock pin
  logic linkClk;        // link clock after edge selection
  logic masterOn;

  // the memory select is wired in but never starts an access
  assign sel = ~ioSelN | ~idSelN; // see [RQ6]
  assign first = sel & ~bus_reg.ack;
  assign ioFirst = first & ~ioSelN;
  assign idFirst = first & ioSelN & ~idSelN;

  // input register source follows the active clocking scheme
  assign inValue = bus_reg.ctrl[pio_pkg::CTRL_DB_EN] ? bus_reg.linkInput : fall_reg.inReg;

  // bus slave, internal latch, control and the two crossings
  always_comb begin
    bus_next = bus_reg;
    // ack follows select by one cycle and stretches with a hold
    bus_next.ack = sel; // see [RQ7] see [RQ8]
    if (first) begin
      bus_next.readOut = rdWrN;
      bus_next.acc = ioFirst ? pio_pkg::ACC_IO : pio_pkg::ACC_ID;
    end
    // io reads: readback, input register, control, else zero
    if (ioFirst && rdWrN) begin
      if (addr == pio_pkg::IDX_OUT_LOW) begin
        bus_next.rdData = bus_reg.intLatch[15:0]; // see [RQ14] see [RQ22]
      end else if (addr == pio_pkg::IDX_OUT_HIGH) begin
        bus_next.rdData = {8'h00, bus_reg.intLatch[23:16]}; // see [RQ14] see [RQ22]
      end else if (addr == pio_pkg::IDX_IN_LOW) begin
        bus_next.rdData = inValue[15:0]; // see [RQ15]
      end else if (addr == pio_pkg::IDX_IN_HIGH) begin
        bus_next.rdData = {8'h00, inValue[23:16]}; // see [RQ15]
      end else if (addr == pio_pkg::IDX_CTRL) begin
        bus_next.rdData = {12'h000, bus_reg.ctrl};
      end else begin
        bus_next.rdData = 16'h0000;
      end
    end
    // io writes on the rising edge after select, per byte lane
    if (ioFirst && !rdWrN) begin
      if (addr == pio_pkg::IDX_OUT_LOW) begin
        if (!byteSel0N) begin
          bus_next.intLatch[7:0] = busDataIn[7:0]; // see [RQ9] see [RQ22]
        end
        if (!byteSel1N) begin
          bus_next.intLatch[15:8] = busDataIn[15:8]; // see [RQ9]
        end
      end else if (addr == pio_pkg::IDX_OUT_HIGH) begin
        if (!byteSel0N) begin
          bus_next.intLatch[23:16] = busDataIn[7:0]; // see [RQ9] see [RQ22]
        end
      end else if (addr == pio_pkg::IDX_CTRL) begin
        if (!byteSel0N) begin
          bus_next.ctrl = busDataIn[3:0];
        end
      end
    end
    // two-flop line synchroniser for the non-buffered input register
    bus_next.lineMeta = lineIn;
    bus_next.lineSync = bus_reg.lineMeta;
    // offer the latest latch word to the link side, one at a time
    bus_next.outAckMeta = link_reg.ackTog;
    bus_next.outAckSync = bus_reg.outAckMeta;
    if (bus_reg.outReq == bus_reg.outAckSync && bus_reg.shadow != bus_reg.intLatch) begin
      bus_next.shadow = bus_reg.intLatch;
      bus_next.outReq = ~bus_reg.outReq;
    end
    // take the input word once the link side has offered it
    bus_next.inReqMeta = link_reg.inReq;
    bus_next.inReqSync = bus_reg.inReqMeta;
    if (bus_reg.inReqSync != bus_reg.inAck) begin
      bus_next.linkInput = link_reg.hold;
      bus_next.inAck = bus_reg.inReqSync;
    end
  end

  // bus-clock registers, all from the carrier clock
  always_ff @(posedge clk or negedge rstn) begin // see [RQ5]
    if (!rstn) begin
      bus_reg.intLatch <= pio_pkg::LINE_RESET; // see [RQ21]
      bus_reg.ctrl <= pio_pkg::CTRL_RESET; // see [RQ13]
      bus_reg.ack <= 1'b0;
      bus_reg.readOut <= 1'b0;
      bus_reg.acc <= pio_pkg::ACC_IO;
      bus_reg.rdData <= 16'h0000;
      bus_reg.lineMeta <= 24'h000000;
      bus_reg.lineSync <= 24'h000000;
      bus_reg.shadow <= pio_pkg::LINE_RESET;
      bus_reg.outReq <= 1'b0;
      bus_reg.outAckMeta <= 1'b0;
      bus_reg.outAckSync <= 1'b0;
      bus_reg.inReqMeta <= 1'b0;
      bus_reg.inReqSync <= 1'b0;
      bus_reg.inAck <= 1'b0;
      bus_reg.linkInput <= 24'h000000;
    end else begin
      bus_reg <= bus_next;
    end
  end

  // without double buffering both registers move on the falling edge
  always_comb begin
    fall_next = fall_reg;
    fall_next.lineLatch = bus_reg.intLatch; // see [RQ10]
    fall_next.inReg = bus_reg.lineSync; // see [RQ16]
  end

  always_ff @(negedge clk or negedge rstn) begin
    if (!rstn) begin
      fall_reg.lineLatch <= pio_pkg::LINE_RESET;
      fall_reg.inReg <= 24'h000000;
    end else begin
      fall_reg <= fall_next;
    end
  end

  // clock source and edge; change these bits only with buffering off,
  // since switching the source mid-cycle can glitch the link clock
  assign linkSrc = bus_reg.ctrl[pio_pkg::CTRL_MODE] ? lineIn[pio_pkg::SLAVE_IN_LINE] : dbClk; // see [RQ19]
  assign linkClk = linkSrc ^ bus_reg.ctrl[pio_pkg::CTRL_POL]; // see [RQ12]

  // link side: line latch and input register load on the same edge
  always_comb begin
    link_next = link_reg;
    link_next.reqMeta = bus_reg.outReq;
    link_next.reqSync = link_reg.reqMeta;
    link_next.lineLatch = link_reg.copy; // see [RQ11]
    if (link_reg.reqSync != link_reg.ackTog) begin
      // shadow is stable while the request is open
      link_next.copy = bus_reg.shadow;
      link_next.lineLatch = bus_reg.shadow; // see [RQ11]
      link_next.ackTog = link_reg.reqSync;
    end
    link_next.inCapture = lineIn; // see [RQ16]
    link_next.inAckMeta = bus_reg.inAck;
    link_next.inAckSync = link_reg.inAckMeta;
    // words captured while a transfer is open are skipped, not queued
    if (link_reg.inReq == link_reg.inAckSync) begin
      link_next.hold = link_reg.inCapture;
      link_next.inReq = ~link_reg.inReq;
    end
  end

  // the link clock may stop between bursts; nothing here needs it to run
  always_ff @(posedge linkClk or negedge rstn) begin
    if (!rstn) begin
      link_reg.reqMeta <= 1'b0;
      link_reg.reqSync <= 1'b0;
      link_reg.ackTog <= 1'b0;
      link_reg.copy <= pio_pkg::LINE_RESET;
      link_reg.lineLatch <= pio_pkg::LINE_RESET;
      link_reg.inCapture <= 24'h000000;
      link_reg.hold <= 24'h000000;
      link_reg.inReq <= 1'b0;
      link_reg.inAckMeta <= 1'b0;
      link_reg.inAckSync <= 1'b0;
    end else begin
      link_reg <= link_next;
    end
  end

  // identification memory, read through the id select
  pio_ident_memory #(
    .MFR_CODE(MFR_CODE),
    .MODEL_CODE(MODEL_CODE),
    .REV_CODE(REV_CODE),
    .CRC_CODE(CRC_CODE)
  ) u_ident_memory (
    .clk(clk),
    .rstn(rstn),
    .readEn(idFirst & rdWrN), // see [RQ1]
    .readIndex(addr),
    .readData(idData)
  );

  // data bus: driven only while acknowledging a read
  assign busDataOut = (bus_reg.acc == pio_pkg::ACC_ID) ? {8'h00, idData} : bus_reg.rdData;
  assign busDataOe = bus_reg.ack & bus_reg.readOut;
  assign ackN = ~bus_reg.ack; // see [RQ7]

  // active line latch depends on the buffering mode
  assign lineLatch = bus_reg.ctrl[pio_pkg::CTRL_DB_EN] ? link_reg.lineLatch : fall_reg.lineLatch;
  assign masterOn = bus_reg.ctrl[pio_pkg::CTRL_MODE] & bus_reg.ctrl[pio_pkg::CTRL_MASTER];

  // open-collector drivers: only ever pull low
  assign lineOut = 24'h000000;
  genvar gi;
  generate
    for (gi = 0; gi < pio_pkg::LINE_COUNT; gi++) begin : g_line
      if (gi == pio_pkg::MASTER_OUT_LINE) begin : g_master
        // master pulls the line low while the external clock is low
        assign lineOe[gi] = masterOn ? ~dbClk : ~lineLatch[gi]; // see [RQ18] see [RQ20]
      end else begin : g_plain
        assign lineOe[gi] = ~lineLatch[gi]; // see [RQ21]
      end
    end
  endgenerate

  // ack one cycle after any answered select
  property p_ack_follows_sel;
    @(posedge clk) disable iff (!rstn)
    sel |=> !ackN;
  endproperty
  a_ack_follows_sel: assert property (p_ack_follows_sel) // see [RQ7]
    else $error("ack missing after select");

  // ack stretches over held select, then drops
  property p_ack_hold;
    @(posedge clk) disable iff (!rstn)
    sel [*3] ##1 !sel |-> !ackN ##1 ackN;
  endproperty
  a_ack_hold: assert property (p_ack_hold) // see [RQ8]
    else $error("ack not held for the hold cycles");

  // a memory select alone never gets an answer
  property p_mem_ignored;
    @(posedge clk) disable iff (!rstn)
    (!memSelN && ioSelN && idSelN) |=> (ackN && !busDataOe);
  endproperty
  a_mem_ignored: assert property (p_mem_ignored) // see [RQ6]
    else $error("memory select was answered");

  // full-word write lands in the low half of the internal latch
  property p_write_low;
    @(posedge clk) disable iff (!rstn)
    (ioFirst && !rdWrN && addr == pio_pkg::IDX_OUT_LOW && !byteSel0N && !byteSel1N)
      |=> bus_reg.intLatch[15:0] == $past(busDataIn);
  endproperty
  a_write_low: assert property (p_write_low) // see [RQ9]
    else $error("write not captured into internal latch");

  // readback of the low word one cycle on, upper byte of high word zero
  property p_readback;
    @(posedge clk) disable iff (!rstn)
    (ioFirst && rdWrN && addr == pio_pkg::IDX_OUT_LOW)
      |=> busDataOe && busDataOut == $past(bus_reg.intLatch[15:0]);
  endproperty
  a_readback: assert property (p_readback) // see [RQ14]
    else $error("readback differs from internal latch");

  property p_high_zero;
    @(posedge clk) disable iff (!rstn)
    (ioFirst && rdWrN && (addr == pio_pkg::IDX_OUT_HIGH || addr == pio_pkg::IDX_IN_HIGH))
      |=> busDataOut[15:8] == 8'h00;
  endproperty
  a_high_zero: assert property (p_high_zero) // see [RQ22]
    else $error("unused upper byte not zero");

  // falling-edge latch tracks the internal latch
  property p_fall_load;
    @(negedge clk) disable iff (!rstn)
    !bus_reg.ctrl[pio_pkg::CTRL_DB_EN] |=> fall_reg.lineLatch == $past(bus_reg.intLatch);
  endproperty
  a_fall_load: assert property (p_fall_load) // see [RQ10]
    else $error("line latch missed the falling edge load");

  // the drivers only pull low, and released bits float
  property p_open_collector;
    @(posedge clk) disable iff (!rstn)
    lineOut == 24'h000000 && lineOe[21:0] == ~lineLatch[21:0];
  endproperty
  a_open_collector: assert property (p_open_collector) // see [RQ21]
    else $error("line driver not open collector");

  // master mode mirrors the external clock on line 23
  property p_master_redrive;
    @(posedge clk) disable iff (!rstn)
    masterOn |-> lineOe[pio_pkg::MASTER_OUT_LINE] == !dbClk;
  endproperty
  a_master_redrive: assert property (p_master_redrive) // see [RQ18]
    else $error("master clock not redriven");

  // identification bytes at the first and count locations
  property p_id_magic;
    @(posedge clk) disable iff (!rstn)
    (idFirst && rdWrN && addr == pio_pkg::ID_IDX_I) |=> busDataOut == {8'h00, pio_pkg::ID_ASCII_I};
  endproperty
  a_id_magic: assert property (p_id_magic) // see [RQ2]
    else $error("identification first byte wrong");

  property p_id_count;
    @(posedge clk) disable iff (!rstn)
    (idFirst && rdWrN && addr == pio_pkg::ID_IDX_COUNT) |=> busDataOut[7:0] == pio_pkg::ID_USED_COUNT;
  endproperty
  a_id_count: assert property (p_id_count) // see [RQ3]
    else $error("identification byte count wrong");

endmodule : pio_parallel_io

// ==== dv/pio_carrier_model.sv ====
// carrier-side bus master model driving the io, id and memory selects
`timescale 1ns/1ps
module pio_carrier_model (
  input wire logic clk,
  output logic ioSelN,
  output logic idSelN,
  output logic memSelN,
  output logic rdWrN,
  output logic [5:0] addr,
  output logic [15:0] busDataIn,
  output logic byteSel0N,
  output logic byteSel1N,
  input wire logic ackN,
  input wire logic [15:0] busDataOut,
  input wire logic busDataOe
);
  // idle bus at time zero
  initial begin
    ioSelN = 1'b1;
    idSelN = 1'b1;
    memSelN = 1'b1;
    rdWrN = 1'b1;
    addr = 6'h00;
    busDataIn = 16'h0000;
    byteSel0N = 1'b1;
    byteSel1N = 1'b1;
  end

  // one transfer: sel 0 io, 1 id, 2 memory; holds stretch the select
  task automatic access(input int sel, input logic rd, input logic [5:0] a,
      input logic [15:0] d, input logic [1:0] bsN, input int holds,
      output logic [15:0] q, output logic ok);
    int n;
    ok = 1'b1;
    q = 16'h0000;
    @(posedge clk);
    ioSelN <= (sel != 0);
    idSelN <= (sel != 1);
    memSelN <= (sel != 2);
    rdWrN <= rd;
    addr <= a;
    busDataIn <= d;
    {byteSel1N, byteSel0N} <= bsN;
    @(posedge clk);
    // an answer before the select was taken is wrong
    if (ackN !== 1'b1) ok = 1'b0;
    for (n = 0; n <= holds; n++) begin
      @(posedge clk);
      if (ackN !== (sel == 2)) ok = 1'b0;
      if (busDataOe !== (rd && sel != 2)) ok = 1'b0;
      q = busDataOut;
    end
    ioSelN <= 1'b1;
    idSelN <= 1'b1;
    memSelN <= 1'b1;
    byteSel0N <= 1'b1;
    byteSel1N <= 1'b1;
    // released data shows the inverse so stale values never pass
    busDataIn <= ~d;
    @(posedge clk);
  endtask : access
endmodule : pio_carrier_model

// ==== dv/pio_parallel_io_bench.sv ====
// self-checking bench for the parallel io block with its carrier model
`timescale 1ns/1ps
`define CHK(a, b) begin samplesChecked++; if ((a) !== (b)) begin errCount++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module pio_parallel_io_bench;
  localparam logic [7:0] MFR = 8'h3C;   // arbitrary value
  localparam logic [7:0] MODEL = 8'h7E; // arbitrary value
  localparam logic [7:0] REV = 8'h05;   // arbitrary value
  localparam logic [7:0] CRC = 8'h9D;   // arbitrary value
  logic clk, rstn, dbClk, ioSelN, idSelN, memSelN, rdWrN, ackN, busDataOe;
  logic byteSel0N, byteSel1N, okAck;
  logic loopBack = 1'b0; // line 23 wired to line 24 in master tests
  logic [5:0] addr;
  logic [15:0] busDataIn, busDataOut, rdQ;
  logic [23:0] lineIn, lineOut, lineOe, pinLvl;
  logic [23:0] ext = 24'hFFFFFF; // far-end drive, pull-up where released
  logic [23:0] expLatch;         // reference internal latch
  int errCount = 0;
  int samplesChecked = 0;
  int cycles = 0;
  int seed = 80188;

  // open-collector pins: low if either side pulls
  assign pinLvl = ~lineOe & ext;
  assign lineIn = {(loopBack ? pinLvl[22] : pinLvl[23]), pinLvl[22:0]};

  pio_parallel_io #(.MFR_CODE(MFR), .MODEL_CODE(MODEL), .REV_CODE(REV), .CRC_CODE(CRC))
  i_pio_parallel_io (.clk(clk), .rstn(rstn), .dbClk(dbClk), .ioSelN(ioSelN),
    .idSelN(idSelN), .memSelN(memSelN), .rdWrN(rdWrN), .addr(addr), .busDataIn(busDataIn),
    .busDataOut(busDataOut), .busDataOe(busDataOe), .byteSel0N(byteSel0N),
    .byteSel1N(byteSel1N), .ackN(ackN), .lineIn(lineIn), .lineOut(lineOut), .lineOe(lineOe));

  pio_carrier_model i_pio_carrier_model (.clk(clk), .ioSelN(ioSelN), .idSelN(idSelN),
    .memSelN(memSelN), .rdWrN(rdWrN), .addr(addr), .busDataIn(busDataIn),
    .byteSel0N(byteSel0N), .byteSel1N(byteSel1N), .ackN(ackN), .busDataOut(busDataOut),
    .busDataOe(busDataOe));

  // bus clock, 50 ns
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      errCount++;
      reportAndStop();
    end
  end

  // xorshift source for data and line patterns
  function automatic int nextRand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : nextRand

  // expected identification word per index
  function automatic logic [15:0] idExp(input int i);
    case (i)
      0: return 16'h0049;
      1: return 16'h0050;
      2: return 16'h0041;
      3: return 16'h0043;
      4: return {8'h00, MFR};
      5: return {8'h00, MODEL};
      6: return {8'h00, REV};
      10: return 16'h000C;
      11: return {8'h00, CRC};
      default: return 16'h0000;
    endcase
  endfunction : idExp

  // one bus transfer with the acknowledge timing checked
  task automatic acc(input int sel, input logic rd, input int a, input int d,
      input int holds = 0, input logic [1:0] bsN = 2'b00);
    i_pio_carrier_model.access(sel, rd, 6'(a), 16'(d), bsN, holds, rdQ, okAck);
    `CHK(okAck, 1'b1)
  endtask : acc

  // read and compare
  task automatic rdChk(input int sel, input int a, input logic [15:0] exp);
    acc(sel, 1'b1, a, 0);
    `CHK(rdQ, exp)
  endtask : rdChk

  // link clock bursts, 15 ns period, stopped between bursts
  task automatic linkRun(input int n);
    #3;
    repeat (2 * n) #7.5 dbClk = ~dbClk;
  endtask : linkRun

  // verdict
  task automatic reportAndStop();
    $display("checks %0d errors %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : reportAndStop

  // main sequence
  initial begin
    int i, p, v;
    logic [23:0] oldLatch;
    rstn = 1'b0;
    dbClk = 1'b0;
    expLatch = 24'hFFFFFF;
    repeat (5) @(posedge clk);
    `CHK(lineOe, 24'h000000)
    rstn <= 1'b1;
    rdChk(0, 0, 16'hFFFF);
    rdChk(0, 1, 16'h00FF);
    rdChk(0, 4, 16'h0000);
    for (i = 0; i < 32; i++) rdChk(1, i, idExp(i));
    acc(2, 1'b1, 0, 0);
    acc(0, 1'b1, 0, 0, 3);
    // random writes with lane strobes, readback, lines and inputs
    for (i = 0; i < 8; i++) begin
      v = nextRand();
      acc(0, 1'b0, 0, v, 0, {i[0], 1'b0});
      expLatch[7:0] = v[7:0];
      if (!i[0]) expLatch[15:8] = v[15:8];
      acc(0, 1'b0, 1, v >> 16);
      expLatch[23:16] = v[23:16];
      @(posedge clk);
      ext <= 24'(nextRand());
      repeat (5) @(posedge clk);
      `CHK(lineOe, ~expLatch)
      rdChk(0, 0, expLatch[15:0]);
      rdChk(0, 1, {8'h00, expLatch[23:16]});
      rdChk(0, 2, expLatch[15:0] & ext[15:0]);
      rdChk(0, 3, {8'h00, expLatch[23:16] & ext[23:16]});
    end
    // double buffering on each polarity
    for (p = 0; p < 2; p++) begin
      // let the link side catch up before buffering takes over the lines
      linkRun(12);
      repeat (4) @(posedge clk);
      linkRun(12);
      repeat (4) @(posedge clk);
      acc(0, 1'b0, 4, {p[0], 1'b1});
      rdChk(0, 4, {14'h0000, p[0], 1'b1});
      oldLatch = expLatch;
      v = nextRand();
      acc(0, 1'b0, 0, v);
      expLatch[15:0] = v[15:0];
      ext <= 24'(nextRand());
      repeat (6) @(posedge clk);
      `CHK(lineOe, ~oldLatch)
      linkRun(12);
      repeat (4) @(posedge clk);
      linkRun(12);
      repeat (4) @(posedge clk);
      `CHK(lineOe, ~expLatch)
      // one more burst so the input word taken after the line change returns
      linkRun(12);
      repeat (4) @(posedge clk);
      rdChk(0, 2, expLatch[15:0] & ext[15:0]);
    end
    acc(0, 1'b0, 4, 0);
    // master setup: line 23 low, line 24 released before the mode bits
    expLatch[23:22] = 2'b10;
    acc(0, 1'b0, 1, expLatch[23:16]);
    @(posedge clk);
    ext <= 24'hFFFFFF;
    loopBack = 1'b1;
    acc(0, 1'b0, 4, 4'hC);
    dbClk = 1'b1;
    repeat (2) @(posedge clk);
    `CHK(lineOe[22], 1'b0)
    dbClk = 1'b0;
    repeat (2) @(posedge clk);
    `CHK(lineOe[22], 1'b1)
    acc(0, 1'b0, 4, 4'hD);
    v = nextRand();
    acc(0, 1'b0, 0, v);
    expLatch[15:0] = v[15:0];
    linkRun(12);
    repeat (4) @(posedge clk);
    linkRun(12);
    repeat (4) @(posedge clk);
    `CHK(lineOe[15:0], ~expLatch[15:0])
    reportAndStop();
  end
endmodule : pio_parallel_io_bench
